// File: bench/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// host side of the register port
module host_bus_model (
	// clock
	input  wire logic        clock,
	// register port
	output var  logic [7:0]  reg_addr,
	output var  logic [15:0] reg_wdata,
	output var  logic        reg_wr,
	output var  logic        reg_rd,
	input  wire logic [15:0] reg_rdata
);
	// idle values at time zero
	initial begin
		reg_addr  = 8'h00;
		reg_wdata = 16'h0000;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
	end

	// one cycle write; address and data flip after so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr    <= 1'b0;
		reg_addr  <= ~a;
		reg_wdata <= ~d;
	endtask

	// one cycle read; data stands only in the following cycle
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clock);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd   <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
	endtask
endmodule // host_bus_model
`default_nettype wire

// File: bench/power_mgmt_wake_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// top of the bench
module power_mgmt_wake_control_tb;
	import pm_wake_pkg::*;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        power_up_rst = 1'b1;
	logic        system_rst_pin = 1'b0;
	logic        skip_bit = 1'b0;
	logic        eeprom_load = 1'b0;
	logic        wake_ev = 1'b0;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	logic        wake_pin;
	logic        soft_reset_out;
	logic        irq;
	logic [15:0] d;
	int          failures = 0;
	int          n_tests = 0;
	int          n;

	power_mgmt_wake_control uut (.clock(clock), .rst(rst), .power_up_rst(power_up_rst),
		.system_rst_pin(system_rst_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.eeprom_skip_reset_bit(skip_bit), .eeprom_load(eeprom_load),
		.wake_event_pulse(wake_ev), .wake_request_pin(wake_pin),
		.soft_reset_out(soft_reset_out), .irq(irq));
	host_bus_model host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	// ========================================
	// helpers
	initial begin
		forever #50 clock = ~clock;
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	// counts soft reset cycles from the cycle after the taking edge
	task automatic cnt_sr(output int c);
		c = 0;
		repeat (8) begin
			#1;
			if (soft_reset_out === 1'b1) c++;
			@(posedge clock);
		end
	endtask

	// line codes: 0 wake event, 1 hardware reset, 2 eeprom load, else system reset pin
	task automatic set_line(input int which, input logic v);
		case (which)
			0: wake_ev <= v;
			1: rst <= v;
			2: eeprom_load <= v;
			default: system_rst_pin <= v;
		endcase
	endtask

	task automatic pulse(input int cycles, input int which);
		@(posedge clock);
		set_line(which, 1'b1);
		repeat (cycles) @(posedge clock);
		set_line(which, 1'b0);
	endtask

	// ========================================
	// scenarios
	task automatic t_reset;
		host.rd(power_mgmt_control_status_offset, d);
		chk("power_mgmt_control_status after power-up", 16'h0000, d);
		host.rd(8'h20, d);
		chk("unmapped read", 16'h0000, d);
		$display("test reset done");
	endtask

	task automatic t_wake;
		pulse(1, 0);
		host.rd(power_mgmt_control_status_offset, d);
		chk("flag set", 16'h8000, d);
		chk("pin gated off", 16'h0000, {15'h0, wake_pin});
		chk("irq masked", 16'h0000, {15'h0, irq});
		host.wr(power_mgmt_control_status_offset, 16'h0100);
		host.rd(power_mgmt_control_status_offset, d);
		chk("write zero keeps flag", 16'h8100, d);
		chk("pin on", 16'h0001, {15'h0, wake_pin});
		host.wr(irq_mask_offset, 16'h0001);
		#1;
		chk("irq unmasked", 16'h0001, {15'h0, irq});
		host.rd(irq_status_offset, d);
		chk("irq status", 16'h0001, d);
		chk("irq after read", 16'h0000, {15'h0, irq});
		pulse(2, 1);
		host.rd(power_mgmt_control_status_offset, d);
		chk("flag and gate kept over reset", 16'h8100, d);
		host.wr(power_mgmt_control_status_offset, 16'h8100);
		host.rd(power_mgmt_control_status_offset, d);
		chk("flag cleared by one", 16'h0100, d);
		chk("pin dropped", 16'h0000, {15'h0, wake_pin});
		$display("test wake done");
	endtask

	task automatic t_pstate;
		for (int i = 0; i < 4; i++) begin
			host.wr(power_mgmt_control_status_offset, 16'(i));
			host.rd(power_mgmt_control_status_offset, d);
			chk("power state", 16'(i), d);
		end
		host.wr(power_mgmt_control_status_offset, 16'h7eff);
		host.rd(power_mgmt_control_status_offset, d);
		chk("reserved and skip ignored", 16'h0003, d);
		host.wr(irq_mask_offset, 16'h0003);
		host.wr(power_mgmt_control_status_offset, 16'h0100);
		cnt_sr(n);
		chk("soft reset length", 16'(sreset_cycles), 16'(n));
		host.rd(irq_status_offset, d);
		chk("soft reset status", 16'h0002, d);
		host.rd(irq_mask_offset, d);
		chk("mask lost on soft reset", 16'h0000, d);
		host.rd(power_mgmt_control_status_offset, d);
		chk("gate kept over soft reset", 16'h0100, d);
		$display("test power state done");
	endtask

	task automatic t_skip;
		@(posedge clock);
		skip_bit <= 1'b1;
		pulse(1, 2);
		host.wr(irq_mask_offset, 16'h0002);
		host.wr(power_mgmt_control_status_offset, 16'h0003);
		host.wr(power_mgmt_control_status_offset, 16'h0000);
		cnt_sr(n);
		chk("no soft reset", 16'h0000, 16'(n));
		host.rd(power_mgmt_control_status_offset, d);
		chk("skip loaded", 16'h0008, d);
		host.rd(irq_mask_offset, d);
		chk("mask kept without soft reset", 16'h0002, d);
		$display("test skip done");
	endtask

	task automatic t_sys;
		host.wr(power_mgmt_control_status_offset, 16'h0103);
		pulse(1, 0);
		pulse(4, 4);
		repeat (4) @(posedge clock);
		host.rd(power_mgmt_control_status_offset, d);
		chk("system reset to d0 keeps wake context", 16'h8108, d);
		chk("pin kept over system reset", 16'h0001, {15'h0, wake_pin});
		host.rd(pm_status_offset, d);
		chk("uninitialised after system reset", 16'h0001, d);
		host.rd(irq_mask_offset, d);
		chk("mask lost on system reset", 16'h0000, d);
		$display("test system reset done");
	endtask

	// ========================================
	// verdict, reached from the main sequence and the watchdog
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		power_up_rst <= 1'b0;
		t_reset();
		t_wake();
		t_pstate();
		t_skip();
		t_sys();
		finish_test();
	end

	// the tests take about a hundred cycles; give them ample slack
	initial begin
		#1ms;
		failures++;
		finish_test();
	end
endmodule // power_mgmt_wake_control_tb
`default_nettype wire

// File: hw/pm_sync2.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// two flop synchroniser for pin inputs
module pm_sync2 #(
	parameter int unsigned width = 1
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst,
	// data
	input  wire logic [width-1:0] async_in,
	output logic      [width-1:0] sync_out
);
	logic [width-1:0] meta_q;

	// second flop is the only reader of the first
	always_ff @(posedge clock) begin
		if (rst) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // pm_sync2
`default_nettype wire

// File: hw/pm_wake_pkg.sv
package pm_wake_pkg;

	// ========================================
	// register map
	localparam logic [7:0]  power_mgmt_control_status_offset       = 8'h08;
	localparam logic [7:0]  irq_status_offset = 8'h0a;
	localparam logic [7:0]  irq_mask_offset   = 8'h0c;
	localparam logic [7:0]  pm_status_offset  = 8'h0e;

	// ========================================
	// field positions of the power management register
	localparam int unsigned wake_flag_bit  = 15;
	localparam int unsigned wake_gate_bit  = 8;
	localparam int unsigned skip_reset_bit = 3;
	localparam int unsigned pstate_lsb     = 0;
	localparam int unsigned pstate_msb     = 1;

	// ========================================
	// interrupt status layout
	localparam int unsigned irq_wake_bit   = 0;
	localparam int unsigned irq_sreset_bit = 1;
	localparam int unsigned irq_bits       = 2;

	// ========================================
	// power state encodings and reset values
	typedef enum logic [1:0] {
		pstate_d0    = 2'h0,
		pstate_d1    = 2'h1,
		pstate_d2    = 2'h2,
		pstate_d3hot = 2'h3
	} pstate_t;

	localparam logic [15:0] reg_zero       = 16'h0000;
	localparam logic [1:0]  irq_zero       = 2'h0;

	// ========================================
	// soft reset pulse length in cycles
	localparam logic [3:0]  sreset_cycles  = 4'h4;

endpackage

// File: hw/power_mgmt_wake_control.sv
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RQ1: a wake event sets the wake event flag at bit 15 of the power management register.
// RQ2: the wake request pin is high whenever the flag is set and the wake pin gate is one.
// RQ3: the flag clears on power-up reset or a host write of one; writing zero keeps it.
// RQ4: hardware and software resets leave the flag untouched.
// RQ5: the wake request pin drops as soon as the flag is clear.
// RQ6: with the wake pin gate at zero the wake request pin never rises.
// RQ7: the wake pin gate clears on power-up reset and survives a software reset.
// RQ8: with skip-reset at one a host move from D3hot to D0 causes no internal reset.
// RQ9: with skip-reset at zero a host move from D3hot to D0 fires an internal reset.
// RQ10: a system reset from D3hot returns the block to uninitialised D0, keeping only wake context.
// RQ11: skip-reset is loaded from the eeprom bit and host writes cannot alter it.
// RQ12: the two-bit power state takes host writes and reads back the current state.
// RQ13: power state codes are 00 D0, 01 D1, 10 D2, 11 D3hot.
// RQ14: reserved bits 14-9, 7-4 and 2 read zero and ignore writes.
// RQ15: the wake event source is a one-cycle pulse from the receive logic.
module power_mgmt_wake_control
	import pm_wake_pkg::*;
(
	// clock and resets
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        power_up_rst,
	input  wire logic        system_rst_pin,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// eeprom configuration
	input  wire logic        eeprom_skip_reset_bit,
	input  wire logic        eeprom_load,
	// receive logic
	input  wire logic        wake_event_pulse,
	// outputs
	output logic             wake_request_pin,
	output logic             soft_reset_out,
	output logic             irq
);

	// ========================================
	// pin synchroniser for the system reset
	logic system_rst_s;

	pm_sync2 #(
		.width(1)
	) u_sync (
		.clock    (clock),
		.rst      (power_up_rst),
		.async_in (system_rst_pin),
		.sync_out (system_rst_s)
	);

	// ========================================
	// address decode
	wire sel_power_mgmt_control_status   = (reg_addr == power_mgmt_control_status_offset);
	wire sel_istat  = (reg_addr == irq_status_offset);
	wire sel_imask  = (reg_addr == irq_mask_offset);
	wire sel_pstat  = (reg_addr == pm_status_offset);
	wire wr_power_mgmt_control_status    = reg_wr && sel_power_mgmt_control_status;
	wire wr_imask   = reg_wr && sel_imask;
	wire rd_istat   = reg_rd && sel_istat;

	// ========================================
	// state
	logic          wake_flag_q;
	logic          wake_gate_q;
	logic          skip_reset_q;
	pstate_t       pstate_q;
	logic [3:0]    sreset_cnt_q;
	logic [1:0]    irq_status_q;
	logic [1:0]    irq_mask_q;
	logic [15:0]   rdata_q;
	logic          uninit_q;

	wire pstate_t  pstate_wr = pstate_t'(reg_wdata[pstate_msb:pstate_lsb]);
	// host driven D3hot to D0 move
	wire to_d0     = wr_power_mgmt_control_status && (pstate_q == pstate_d3hot) && (pstate_wr == pstate_d0);
	wire fire_sreset = to_d0 && !skip_reset_q; // RQ9
	wire sreset_busy = (sreset_cnt_q != 4'h0);
	// a system reset taken in D3hot wipes state regardless of skip-reset
	wire sys_wipe  = rst || system_rst_s; // RQ10
	wire cfg_wipe  = sys_wipe || sreset_busy;

	// ========================================
	// wake flag: only power-up reset clears it besides a write of one
	wire flag_set  = wake_event_pulse; // RQ15
	wire flag_clr  = wr_power_mgmt_control_status && reg_wdata[wake_flag_bit]; // RQ3
	always_ff @(posedge clock) begin
		if (power_up_rst) begin
			wake_flag_q <= 1'b0; // RQ3
		end else if (flag_set) begin
			wake_flag_q <= 1'b1; // RQ1
		end else if (flag_clr) begin
			wake_flag_q <= 1'b0; // RQ3
		end
	end
	// rst and soft reset deliberately absent above, RQ4

	// ========================================
	// wake gate survives software and system resets
	always_ff @(posedge clock) begin
		if (power_up_rst) begin
			wake_gate_q <= 1'b0; // RQ7
		end else if (wr_power_mgmt_control_status) begin
			wake_gate_q <= reg_wdata[wake_gate_bit];
		end
	end

	// pin is a pure gate, so it drops the cycle the flag clears
	assign wake_request_pin = wake_flag_q && wake_gate_q; // RQ2 RQ5 RQ6

	// ========================================
	// skip-reset bit from eeprom only
	always_ff @(posedge clock) begin
		if (power_up_rst) begin
			skip_reset_q <= 1'b0;
		end else if (eeprom_load) begin
			skip_reset_q <= eeprom_skip_reset_bit; // RQ11
		end
	end

	// ========================================
	// power state, held across a skip-reset wake
	always_ff @(posedge clock) begin
		if (power_up_rst || sys_wipe) begin
			pstate_q <= pstate_d0; // RQ10
		end else if (wr_power_mgmt_control_status) begin
			pstate_q <= pstate_wr; // RQ12 RQ13
		end
	end

	// uninitialised marker, set by any reset, cleared by host write
	always_ff @(posedge clock) begin
		if (power_up_rst || cfg_wipe) begin
			uninit_q <= 1'b1;
		end else if (wr_power_mgmt_control_status || wr_imask) begin
			uninit_q <= 1'b0;
		end
	end

	// ========================================
	// internal soft reset pulse; none when skip-reset is set
	always_ff @(posedge clock) begin
		if (power_up_rst || sys_wipe) begin
			sreset_cnt_q <= 4'h0;
		end else if (fire_sreset) begin
			sreset_cnt_q <= sreset_cycles; // RQ8 RQ9
		end else if (sreset_busy) begin
			sreset_cnt_q <= sreset_cnt_q - 4'h1;
		end
	end
	assign soft_reset_out = sreset_busy;

	// ========================================
	// interrupts: sticky status, set wins over read clear
	wire [1:0] irq_ev;
	assign irq_ev[irq_wake_bit]   = wake_event_pulse;
	assign irq_ev[irq_sreset_bit] = fire_sreset;
	always_ff @(posedge clock) begin
		if (power_up_rst) begin
			irq_status_q <= irq_zero;
		end else begin
			irq_status_q <= irq_ev | (rd_istat ? irq_zero : irq_status_q);
		end
	end
	// mask is configuration, lost on any internal reset
	always_ff @(posedge clock) begin
		if (power_up_rst || cfg_wipe) begin
			irq_mask_q <= irq_zero;
		end else if (wr_imask) begin
			irq_mask_q <= reg_wdata[irq_bits-1:0];
		end
	end
	assign irq = |(irq_status_q & irq_mask_q);

	// ========================================
	// read mux; reserved bits stay zero
	logic [15:0] power_mgmt_control_status_view;
	always_comb begin
		power_mgmt_control_status_view = reg_zero; // RQ14
		power_mgmt_control_status_view[wake_flag_bit] = wake_flag_q;
		power_mgmt_control_status_view[wake_gate_bit] = wake_gate_q;
		power_mgmt_control_status_view[skip_reset_bit] = skip_reset_q;
		power_mgmt_control_status_view[pstate_msb:pstate_lsb] = pstate_q; // RQ12
	end
	wire [15:0] istat_view = {14'h0, irq_status_q};
	wire [15:0] imask_view = {14'h0, irq_mask_q};
	wire [15:0] pstat_view = {14'h0, sreset_busy, uninit_q};
	wire [15:0] rd_mux = sel_power_mgmt_control_status  ? power_mgmt_control_status_view :
	                     sel_istat ? istat_view :
	                     sel_imask ? imask_view :
	                     sel_pstat ? pstat_view : reg_zero;

	// read data stand one cycle after the strobe only
	always_ff @(posedge clock) begin
		if (power_up_rst) begin
			rdata_q <= reg_zero;
		end else begin
			rdata_q <= reg_rd ? rd_mux : reg_zero;
		end
	end
	assign reg_rdata = rdata_q;

	// ========================================
	// assertions
	property p_flag_set;
		@(posedge clock) disable iff (power_up_rst)
		wake_event_pulse |=> wake_flag_q;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set"); // RQ1

	property p_pin_on;
		@(posedge clock) disable iff (power_up_rst)
		(wake_flag_q && wake_gate_q) |-> wake_request_pin;
	endproperty
	a_pin_on: assert property (p_pin_on) else $error("pin low"); // RQ2

	property p_w1c;
		@(posedge clock) disable iff (power_up_rst)
		(wr_power_mgmt_control_status && reg_wdata[wake_flag_bit] && !wake_event_pulse) |=> !wake_flag_q;
	endproperty
	a_w1c: assert property (p_w1c) else $error("flag not cleared"); // RQ3

	property p_keep_reset;
		@(posedge clock) disable iff (power_up_rst)
		(wake_flag_q && !flag_clr) |=> wake_flag_q;
	endproperty
	a_keep_reset: assert property (p_keep_reset) else $error("flag lost"); // RQ4

	property p_pin_off;
		@(posedge clock) disable iff (power_up_rst)
		!wake_flag_q |-> !wake_request_pin;
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("pin high"); // RQ5

	property p_gate_off;
		@(posedge clock) disable iff (power_up_rst)
		!wake_gate_q |-> !wake_request_pin;
	endproperty
	a_gate_off: assert property (p_gate_off) else $error("gate ignored"); // RQ6

	property p_gate_keep;
		@(posedge clock) disable iff (power_up_rst)
		(!wr_power_mgmt_control_status && sreset_busy) |=> (wake_gate_q == $past(wake_gate_q));
	endproperty
	a_gate_keep: assert property (p_gate_keep) else $error("gate changed"); // RQ7

	sequence s_wake_hot;
		to_d0 && !sys_wipe;
	endsequence

	// four busy cycles, then quiet
	sequence s_sreset_pulse;
		soft_reset_out [*4] ##1 !soft_reset_out;
	endsequence

	property p_no_sreset;
		@(posedge clock) disable iff (power_up_rst)
		(s_wake_hot ##0 (skip_reset_q && !sreset_busy)) |=> !soft_reset_out;
	endproperty
	a_no_sreset: assert property (p_no_sreset) else $error("spurious reset"); // RQ8

	// a hardware or system reset may legally cut the pulse short
	property p_sreset;
		@(posedge clock) disable iff (power_up_rst || sys_wipe)
		(s_wake_hot ##0 !skip_reset_q) |=> s_sreset_pulse;
	endproperty
	a_sreset: assert property (p_sreset) else $error("reset pulse wrong"); // RQ9

	property p_sys_d0;
		@(posedge clock) disable iff (power_up_rst)
		sys_wipe |=> (pstate_q == pstate_d0) && uninit_q;
	endproperty
	a_sys_d0: assert property (p_sys_d0) else $error("not uninit d0"); // RQ10

	property p_skip_ro;
		@(posedge clock) disable iff (power_up_rst)
		!eeprom_load |=> $stable(skip_reset_q);
	endproperty
	a_skip_ro: assert property (p_skip_ro) else $error("skip changed"); // RQ11

	property p_pstate_rd;
		@(posedge clock) disable iff (power_up_rst)
		(reg_rd && sel_power_mgmt_control_status) |=> (reg_rdata[pstate_msb:pstate_lsb] == $past(pstate_q));
	endproperty
	a_pstate_rd: assert property (p_pstate_rd) else $error("state read"); // RQ12

	property p_rsvd;
		@(posedge clock) disable iff (power_up_rst)
		(reg_rd && sel_power_mgmt_control_status) |=> (reg_rdata[14:9] == 6'h00) && (reg_rdata[7:4] == 4'h0)
			&& !reg_rdata[2];
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits"); // RQ14

	// ========================================
	// interrupt status, read port and configuration keeping
	property p_irq_set;
		@(posedge clock) disable iff (power_up_rst)
		wake_event_pulse |=> irq_status_q[irq_wake_bit];
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("wake status not set"); // RQ1

	property p_irq_sticky;
		@(posedge clock) disable iff (power_up_rst)
		(irq_status_q[irq_wake_bit] && !rd_istat) |=> irq_status_q[irq_wake_bit];
	endproperty
	a_irq_sticky: assert property (p_irq_sticky) else $error("wake status lost");

	property p_irq_rc;
		@(posedge clock) disable iff (power_up_rst)
		(rd_istat && !wake_event_pulse && !fire_sreset) |=> (irq_status_q == irq_zero);
	endproperty
	a_irq_rc: assert property (p_irq_rc) else $error("status not cleared by read");

	property p_rdata_idle;
		@(posedge clock) disable iff (power_up_rst)
		!reg_rd |=> (reg_rdata == reg_zero);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");

	property p_sreset_wipe;
		@(posedge clock) disable iff (power_up_rst)
		sreset_busy |=> (irq_mask_q == irq_zero) && uninit_q;
	endproperty
	a_sreset_wipe: assert property (p_sreset_wipe) else $error("config kept over reset"); // RQ9

	property p_pstate_hold;
		@(posedge clock) disable iff (power_up_rst)
		(!wr_power_mgmt_control_status && !sys_wipe) |=> $stable(pstate_q);
	endproperty
	a_pstate_hold: assert property (p_pstate_hold) else $error("power state moved"); // RQ8

	property p_sys_quiet;
		@(posedge clock) disable iff (power_up_rst)
		sys_wipe |=> !soft_reset_out;
	endproperty
	a_sys_quiet: assert property (p_sys_quiet) else $error("soft reset on system reset"); // RQ10

	property p_gate_wr;
		@(posedge clock) disable iff (power_up_rst)
		wr_power_mgmt_control_status |=> (wake_gate_q == $past(reg_wdata[wake_gate_bit]));
	endproperty
	a_gate_wr: assert property (p_gate_wr) else $error("gate write lost"); // RQ6

endmodule // power_mgmt_wake_control
`default_nettype wire
